// file: include/dec_enc_if.sv
// tracks, evaluation mode and count pulses of one channel
// assumes one clock domain; pulses last one cycle
`timescale 1ns/10ps
`default_nettype none
interface dec_enc_if;
    import dec_pkg::*;
    logic a;
    logic b;
    dec_eval_t eval;
    logic up;
    logic dn;
    modport dec (input a, input b, input eval, output up, output dn);
    modport core (output a, output b, output eval, input up, input dn);
endinterface
`default_nettype wire

// file: include/dec_pkg.sv
// constants and types for the dual gated encoder counter
// assumes a single 20 MHz system clock and synchronous inputs
package dec_pkg;
    localparam int DEC_NUM_CH = 2;
    localparam int DEC_CNT_W = 32;
    localparam int DEC_CTL_W = 16;
    localparam int DEC_STS_W = 16;
    localparam int DEC_CFG_W = 8;

    // signal evaluation codes, field bits 2..0 of counter mode three
    typedef enum logic [2:0] {
        DEC_EVAL_OFF = 3'b000,
        DEC_EVAL_SINGLE = 3'b001,
        DEC_EVAL_DOUBLE = 3'b010,
        DEC_EVAL_QUAD = 3'b011,
        DEC_EVAL_PULSE_DIR = 3'b100
    } dec_eval_t;
    localparam int DEC_EVAL_LSB = 0;
    localparam int DEC_EVAL_MSB = 2;

    // count limits, full signed 32-bit range
    localparam logic [31:0] DEC_CNT_MAX = 32'h7FFFFFFF;
    localparam logic [31:0] DEC_CNT_MIN = 32'h80000000;
    localparam logic [31:0] DEC_CNT_RESET = 32'h00000000;

    // control word bits
    localparam int DEC_CTL_GATE_OPEN = 2;
    localparam int DEC_CTL_CNT_CLEAR = 5;
    localparam int DEC_CTL_FLAG_CLEAR = 6;
    localparam int DEC_CTL_GATE_CLOSE = 10;

    // status word bits
    localparam int DEC_STS_SOFTWARE_COUNT_GATE = 2;
    localparam int DEC_STS_INT_GATE = 5;
    localparam int DEC_STS_DIR_DN = 7;
    localparam int DEC_STS_DIR_UP = 8;
    localparam int DEC_STS_OVF = 11;
    localparam int DEC_STS_UNF = 12;
    localparam int DEC_STS_ZRUN = 13;

    // diagnostic record
    localparam logic [7:0] DEC_REC_SHORT = 8'h00;
    localparam logic [7:0] DEC_REC_FULL = 8'h01;
    localparam int DEC_IDX_W = 5;
    localparam logic [4:0] DEC_REC_SHORT_LEN = 5'h04;
    localparam logic [4:0] DEC_REC_FULL_LEN = 5'h14;
    localparam logic [4:0] DEC_DIAG_MODINFO = 5'h01;
    localparam logic [4:0] DEC_DIAG_CHTYPE = 5'h04;
    localparam logic [4:0] DEC_DIAG_DIAG_BITS_PER_CHANNEL = 5'h05;
    localparam logic [4:0] DEC_DIAG_CHANNEL_COUNT = 5'h06;
    localparam logic [4:0] DEC_DIAG_STAMP = 5'h10;
    localparam logic [3:0] DEC_MOD_CLASS = 4'h8;
    localparam logic DEC_MOD_CHINFO = 1'b1;
    localparam logic [7:0] DEC_DIAG_BITS_PER_CHANNEL_VAL = 8'h00;
    localparam logic [7:0] DEC_RSVD_BYTE = 8'h00;
    localparam logic [31:0] DEC_STAMP_RESET = 32'h00000000;

    // microsecond ticker timing
    localparam int DEC_CLK_PERIOD_NS = 50;
    localparam int DEC_TICK_NS = 1000;
    localparam int DEC_TICK_CYC = DEC_TICK_NS / DEC_CLK_PERIOD_NS;
    localparam int DEC_TICK_W = $clog2(DEC_TICK_CYC);
endpackage

// file: src/dec_dual_counter.sv
// dual 32-bit gated encoder counter with diagnostic record
// assumes control words and tracks synchronous to clk_sys
//
// Contract
// - evaluation code 000b disables the counter
// - codes 001b-011b give quadrature x1/x2/x4
// - code 100b: pulses on a, direction b
// - disabled counter ignores its other settings
// - count only while internal gate open
// - rising gate-open bit opens the gate
// - rising gate-close bit closes the gate
// - gate opening clears the counter
// - counters start at zero
// - limits are full signed 32-bit range
// - forward past max loads min, overflow
// - backward past min loads max, underflow
// - wrap flags sticky until software clears
// - no interrupts, diagnostics only by record
// - record 01h whole, 00h first four
// - module byte: class 1000b, bit4 set
// - channel type byte: fixed seven-bit code
// - diagnostic bits per channel reads 00h
// - channel count byte reads 02h
// - stamp holds microsecond ticker at diagnostic
// - rising bit 6 clears sticky flags
// - overflow status bit 11, underflow 12
// - gate-open control bit 2, close 10
`timescale 1ns/10ps
`default_nettype none
module dec_dual_counter
    import dec_pkg::*;
#(
    parameter int NUM_CH = DEC_NUM_CH,
    // channel type code, value is arbitrary
    parameter logic [6:0] CHTYPE_CODE = 7'h2A
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [NUM_CH-1:0] track_a,
    input wire logic [NUM_CH-1:0] track_b,
    input wire logic [NUM_CH-1:0][DEC_CFG_W-1:0] counter_mode_three_config,
    input wire logic [NUM_CH-1:0][DEC_CTL_W-1:0] ctrl_word,
    output logic [NUM_CH-1:0][DEC_CNT_W-1:0] counter_value,
    output logic [NUM_CH-1:0][DEC_STS_W-1:0] status_word,
    input wire logic diag_event,
    input wire logic diag_rd,
    input wire logic [7:0] record_set_number,
    input wire logic [DEC_IDX_W-1:0] diag_byte_index,
    output logic diag_rd_valid,
    output logic diag_rd_error,
    output logic [7:0] diag_rd_data
);
    typedef struct packed {
        logic [NUM_CH-1:0][DEC_CNT_W-1:0] cnt;
        logic [NUM_CH-1:0][DEC_CTL_W-1:0] ctl_prev;
        logic [NUM_CH-1:0] gate;
        logic [NUM_CH-1:0] ovf;
        logic [NUM_CH-1:0] unf;
        logic [NUM_CH-1:0] zrun;
        logic [NUM_CH-1:0] dir_up;
        logic [NUM_CH-1:0] dir_dn;
        logic [DEC_TICK_W-1:0] us_div;
        logic [31:0] ticker;
        logic [31:0] stamp;
        logic diag_valid;
        logic diag_err;
        logic [7:0] diag_data;
    } dec_core_state_t;

    dec_core_state_t s_r;
    dec_core_state_t s_nxt;
    logic [NUM_CH-1:0] cnt_up;
    logic [NUM_CH-1:0] cnt_dn;
    logic [NUM_CH-1:0] enabled;
    logic [DEC_CTL_W-1:0] rise;
    logic gate_rise;
    logic counted;
    logic [DEC_IDX_W-1:0] rec_len;
    logic [1:0] stamp_sel;

    dec_enc_if enc_if[NUM_CH]();

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            assign enc_if[g].a = track_a[g];
            assign enc_if[g].b = track_b[g];
            assign enc_if[g].eval = dec_eval_t'(
                counter_mode_three_config[g][DEC_EVAL_MSB:DEC_EVAL_LSB]);
            assign cnt_up[g] = enc_if[g].up;
            assign cnt_dn[g] = enc_if[g].dn;
            // code zero switches the channel off
            assign enabled[g] = enc_if[g].eval != DEC_EVAL_OFF;
            dec_edge_decode u_dec (
                .clk_sys(clk_sys),
                .rst(rst),
                .enc(enc_if[g])
            );
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        rise = '0;
        gate_rise = 1'b0;
        counted = 1'b0;
        rec_len = '0;
        stamp_sel = '0;

        // free-running microsecond ticker
        if (s_r.us_div == DEC_TICK_W'(DEC_TICK_CYC - 1)) begin
            s_nxt.us_div = '0;
            s_nxt.ticker = s_r.ticker + 32'h00000001;
        end else begin
            s_nxt.us_div = s_r.us_div + DEC_TICK_W'(1);
        end

        if (diag_event) begin
            s_nxt.stamp = s_r.ticker;
        end

        for (int ch = 0; ch < NUM_CH; ch++) begin
            rise = ctrl_word[ch] & ~s_r.ctl_prev[ch];
            s_nxt.ctl_prev[ch] = ctrl_word[ch];

            // close checked first so it wins
            // bit positions of the two requests
            if (rise[DEC_CTL_GATE_CLOSE]) begin
                s_nxt.gate[ch] = 1'b0;
            end else if (rise[DEC_CTL_GATE_OPEN]) begin
                s_nxt.gate[ch] = 1'b1;
            end
            gate_rise = s_nxt.gate[ch] & ~s_r.gate[ch];

            // flag clear before wrap set, set wins
            if (rise[DEC_CTL_FLAG_CLEAR]) begin
                s_nxt.ovf[ch] = 1'b0;
                s_nxt.unf[ch] = 1'b0;
                s_nxt.zrun[ch] = 1'b0;
            end

            counted = 1'b0;
            // gate opening clears counter, pulse dropped
            if (gate_rise || rise[DEC_CTL_CNT_CLEAR]) begin
                s_nxt.cnt[ch] = DEC_CNT_RESET;
            end else if (s_r.gate[ch] && enabled[ch]) begin
                if (cnt_up[ch]) begin
                    counted = 1'b1;
                    s_nxt.dir_up[ch] = 1'b1;
                    s_nxt.dir_dn[ch] = 1'b0;
                    if (s_r.cnt[ch] == DEC_CNT_MAX) begin
                        s_nxt.cnt[ch] = DEC_CNT_MIN;
                        s_nxt.ovf[ch] = 1'b1;
                    end else begin
                        s_nxt.cnt[ch] = s_r.cnt[ch] + 32'h00000001;
                    end
                end else if (cnt_dn[ch]) begin
                    counted = 1'b1;
                    s_nxt.dir_up[ch] = 1'b0;
                    s_nxt.dir_dn[ch] = 1'b1;
                    if (s_r.cnt[ch] == DEC_CNT_MIN) begin
                        s_nxt.cnt[ch] = DEC_CNT_MAX;
                        s_nxt.unf[ch] = 1'b1;
                    end else begin
                        s_nxt.cnt[ch] = s_r.cnt[ch] - 32'h00000001;
                    end
                end
            end
            // counting onto zero marks a zero run
            if (counted && s_nxt.cnt[ch] == DEC_CNT_RESET) begin
                s_nxt.zrun[ch] = 1'b1;
            end
        end

        // record reads are the only diagnostic path
        // record 00h is the first four bytes of 01h
        s_nxt.diag_valid = diag_rd;
        s_nxt.diag_err = 1'b0;
        s_nxt.diag_data = DEC_RSVD_BYTE;
        if (record_set_number == DEC_REC_SHORT) begin
            rec_len = DEC_REC_SHORT_LEN;
        end else if (record_set_number == DEC_REC_FULL) begin
            rec_len = DEC_REC_FULL_LEN;
        end else begin
            rec_len = '0;
        end
        stamp_sel = 2'(diag_byte_index - DEC_DIAG_STAMP);
        if (diag_rd) begin
            if (diag_byte_index >= rec_len) begin
                s_nxt.diag_err = 1'b1;
            // class in low nibble, channel info bit
            end else if (diag_byte_index == DEC_DIAG_MODINFO) begin
                s_nxt.diag_data = {3'h0, DEC_MOD_CHINFO, DEC_MOD_CLASS};
            // fixed type code, bit 7 reserved
            end else if (diag_byte_index == DEC_DIAG_CHTYPE) begin
                s_nxt.diag_data = {1'b0, CHTYPE_CODE};
            end else if (diag_byte_index == DEC_DIAG_DIAG_BITS_PER_CHANNEL) begin
                s_nxt.diag_data = DEC_DIAG_BITS_PER_CHANNEL_VAL;
            end else if (diag_byte_index == DEC_DIAG_CHANNEL_COUNT) begin
                s_nxt.diag_data = 8'(NUM_CH);
            end else if (diag_byte_index >= DEC_DIAG_STAMP) begin
                s_nxt.diag_data = s_r.stamp[8*stamp_sel +: 8];
            end
        end
    end

    // reset leaves every counter at zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        for (int ch = 0; ch < NUM_CH; ch++) begin
            status_word[ch] = '0;
            status_word[ch][DEC_STS_SOFTWARE_COUNT_GATE] = s_r.gate[ch];
            // internal gate mirrors the software gate
            status_word[ch][DEC_STS_INT_GATE] = s_r.gate[ch];
            status_word[ch][DEC_STS_DIR_DN] = s_r.dir_dn[ch];
            status_word[ch][DEC_STS_DIR_UP] = s_r.dir_up[ch];
            status_word[ch][DEC_STS_OVF] = s_r.ovf[ch];
            status_word[ch][DEC_STS_UNF] = s_r.unf[ch];
            status_word[ch][DEC_STS_ZRUN] = s_r.zrun[ch];
        end
    end

    assign counter_value = s_r.cnt;
    assign diag_rd_valid = s_r.diag_valid;
    assign diag_rd_error = s_r.diag_err;
    assign diag_rd_data = s_r.diag_data;
endmodule
`default_nettype wire

// file: src/dec_edge_decode.sv
// edge decoder for one channel: quadrature or pulse/direction
// assumes tracks synchronous to clk_sys and filtered upstream
`timescale 1ns/10ps
`default_nettype none
module dec_edge_decode
    import dec_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    dec_enc_if.dec enc
);
    typedef struct packed {
        logic primed;
        logic a_prev;
        logic b_prev;
        logic up;
        logic dn;
    } dec_dec_state_t;

    dec_dec_state_t s_r;
    dec_dec_state_t s_nxt;
    logic a_rise;
    logic a_fall;
    logic b_edge;

    always_comb begin
        s_nxt = s_r;
        s_nxt.up = 1'b0;
        s_nxt.dn = 1'b0;
        s_nxt.a_prev = enc.a;
        s_nxt.b_prev = enc.b;
        s_nxt.primed = 1'b1;
        a_rise = enc.a & ~s_r.a_prev;
        a_fall = ~enc.a & s_r.a_prev;
        b_edge = enc.b ^ s_r.b_prev;
        // first cycle after reset has no valid history
        if (s_r.primed) begin
            case (enc.eval)
                DEC_EVAL_SINGLE: begin
                    s_nxt.up = a_rise & ~enc.b;
                    s_nxt.dn = a_fall & ~enc.b;
                end
                DEC_EVAL_DOUBLE: begin
                    s_nxt.up = (a_rise | a_fall) & (enc.a != enc.b);
                    s_nxt.dn = (a_rise | a_fall) & (enc.a == enc.b);
                end
                // quadruple edge, both tracks at once is illegal
                DEC_EVAL_QUAD: begin
                    if ((a_rise | a_fall) && !b_edge) begin
                        s_nxt.up = enc.a != enc.b;
                        s_nxt.dn = enc.a == enc.b;
                    end else if (b_edge && !(a_rise | a_fall)) begin
                        s_nxt.up = enc.a == enc.b;
                        s_nxt.dn = enc.a != enc.b;
                    end
                end
                // pulse on a, direction from b
                DEC_EVAL_PULSE_DIR: begin
                    s_nxt.up = a_rise & ~enc.b;
                    s_nxt.dn = a_rise & enc.b;
                end
                // off and unknown codes give no pulses
                default: begin
                    s_nxt.up = 1'b0;
                    s_nxt.dn = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign enc.up = s_r.up;
    assign enc.dn = s_r.dn;
endmodule
`default_nettype wire

// file: tb/dec_dual_counter_props.sv
// port assertions for the dual gated encoder counter
// assumes dec_pkg compiled first; bound onto every top instance
`timescale 1ns/10ps
`default_nettype none
module dec_dual_counter_props
    import dec_pkg::*;
#(
    parameter int NUM_CH = DEC_NUM_CH,
    parameter logic [6:0] CHTYPE_CODE = 7'h2A
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [NUM_CH-1:0] track_a,
    input wire logic [NUM_CH-1:0] track_b,
    input wire logic [NUM_CH-1:0][DEC_CFG_W-1:0] counter_mode_three_config,
    input wire logic [NUM_CH-1:0][DEC_CTL_W-1:0] ctrl_word,
    input wire logic [NUM_CH-1:0][DEC_CNT_W-1:0] counter_value,
    input wire logic [NUM_CH-1:0][DEC_STS_W-1:0] status_word,
    input wire logic diag_event,
    input wire logic diag_rd,
    input wire logic [7:0] record_set_number,
    input wire logic [DEC_IDX_W-1:0] diag_byte_index,
    input wire logic diag_rd_valid,
    input wire logic diag_rd_error,
    input wire logic [7:0] diag_rd_data
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        gate_open_a: assert property (
            $rose(ctrl_word[i][2]) && !$rose(ctrl_word[i][10])
            && !status_word[i][2] |=> status_word[i][2] && status_word[i][5]
            && counter_value[i] == 32'h0) else $error("gate open failed");
        gate_close_a: assert property (
            $rose(ctrl_word[i][10]) |=> !status_word[i][2]
            && !status_word[i][5]) else $error("gate close failed");
        // two closed samples: a late decoder pulse cannot sneak in
        gate_hold_a: assert property (
            !status_word[i][2] && !$past(status_word[i][2])
            && !$rose(ctrl_word[i][2]) && !$rose(ctrl_word[i][5])
            |=> $stable(counter_value[i])) else $error("closed gate counted");
        wrap_flag_a: assert property (
            $past(counter_value[i]) == DEC_CNT_MAX
            && counter_value[i] == DEC_CNT_MIN |-> status_word[i][11])
            else $error("overflow flag missing");
        unf_flag_a: assert property (
            $past(counter_value[i]) == DEC_CNT_MIN
            && counter_value[i] == DEC_CNT_MAX |-> status_word[i][12])
            else $error("underflow flag missing");
        flag_sticky_a: assert property (
            status_word[i][12:11] != 2'h0 && !$rose(ctrl_word[i][6])
            |=> status_word[i][12:11] != 2'h0) else $error("flag dropped");
        flag_clear_a: assert property (
            $rose(ctrl_word[i][6]) && counter_value[i] != DEC_CNT_MAX
            && counter_value[i] != DEC_CNT_MIN
            |=> status_word[i][12:11] == 2'h0) else $error("flag kept");
    end
    rd_answer_a: assert property (
        diag_rd |=> diag_rd_valid ##1 !diag_rd_valid || $past(diag_rd))
        else $error("read answer timing wrong");
    rd_error_a: assert property (
        diag_rd && (record_set_number > DEC_REC_FULL
        || diag_byte_index >= (record_set_number == DEC_REC_SHORT
        ? DEC_REC_SHORT_LEN : DEC_REC_FULL_LEN))
        |=> diag_rd_error && diag_rd_data == 8'h00)
        else $error("bad read not refused");
    chan_count_a: assert property (
        diag_rd && record_set_number == DEC_REC_FULL
        && diag_byte_index == DEC_DIAG_CHANNEL_COUNT |=> !diag_rd_error
        && diag_rd_data == 8'(NUM_CH)) else $error("channel count wrong");
endmodule
bind dec_dual_counter dec_dual_counter_props #(
    .NUM_CH(NUM_CH), .CHTYPE_CODE(CHTYPE_CODE)
) i_props (
    .clk_sys, .rst, .track_a, .track_b, .counter_mode_three_config,
    .ctrl_word, .counter_value, .status_word, .diag_event, .diag_rd,
    .record_set_number, .diag_byte_index, .diag_rd_valid, .diag_rd_error,
    .diag_rd_data
);
`default_nettype wire

// file: tb/dec_dual_counter_tb.sv
// self-checking bench for the dual gated encoder counter
// assumes package, design, checker and encoder model compiled first
`timescale 1ns/10ps
`default_nettype none
module dec_dual_counter_tb;
    import dec_pkg::*;
    // channel type code, value is arbitrary
    localparam logic [6:0] CHT = 7'h2A;
    logic clk_sys, rst, diag_event, diag_rd, diag_rd_valid, diag_rd_error;
    logic [1:0] track_a, track_b, step, fwd, pd;
    logic [1:0][7:0] cfg;
    logic [1:0][15:0] ctrl, sts;
    logic [1:0][31:0] cnt;
    logic [7:0] rec, rd_data;
    logic [4:0] idx;
    logic [8:0] exp_q[$];
    logic [31:0] seed, cyc, stamp, exp1, v, rv;
    int err_total, num_checks;
    int mexp[5] = '{0, 1, 2, 4, 2};
    dec_dual_counter #(.CHTYPE_CODE(CHT)) i_dut (
        .clk_sys, .rst, .track_a, .track_b,
        .counter_mode_three_config(cfg), .ctrl_word(ctrl),
        .counter_value(cnt), .status_word(sts), .diag_event, .diag_rd,
        .record_set_number(rec), .diag_byte_index(idx), .diag_rd_valid,
        .diag_rd_error, .diag_rd_data(rd_data)
    );
    dec_enc_model i_enc (
        .clk_sys, .rst, .step, .fwd, .pd, .track_a, .track_b
    );
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc <= rst ? 32'h0 : cyc + 32'h1;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // one request edge; the bit drops again so the next call is a new edge
    task automatic req(input int ch, input logic [15:0] bits);
        @(posedge clk_sys);
        ctrl[ch] <= bits;
        @(posedge clk_sys);
        ctrl[ch] <= 16'h0;
        tick(1);
        #1;
    endtask
    task automatic mv(input int ch, input logic dir, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            step[ch] <= 1'b1;
            fwd[ch] <= dir;
            @(posedge clk_sys);
            step[ch] <= 1'b0;
            tick(3);
        end
        #1;
    endtask
    function automatic logic [8:0] eb(input logic [7:0] r, input int i);
        if (r > 8'h01 || i >= (r == 8'h00 ? 4 : 20)) return 9'h100;
        case (i)
            1: return {1'b0, 3'h0, 1'b1, 4'h8};
            4: return {2'h0, CHT};
            6: return 9'h002;
            16, 17, 18, 19: return {1'b0, stamp[8*(i-16) +: 8]};
            default: return 9'h000;
        endcase
    endfunction
    task automatic rd(input logic [7:0] r, input int i);
        @(posedge clk_sys);
        diag_rd <= 1'b1;
        rec <= r;
        idx <= 5'(i);
        exp_q.push_back(eb(r, i));
        @(posedge clk_sys);
        diag_rd <= 1'b0;
    endtask
    // answers come back in request order, so the oldest note matches
    always @(posedge clk_sys) begin
        if (diag_rd_valid === 1'b1) begin
            v = exp_q.size() > 0 ? {23'h0, exp_q.pop_front()} : 32'h1FF;
            chk({23'h0, diag_rd_error, rd_data}, v);
        end
    end
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        err_total++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        {diag_event, diag_rd, step, fwd, pd, rec, idx} = '0;
        cfg = '0;
        ctrl = '0;
        stamp = 32'h0;
        seed = 32'h8C553CBB;
        tick(4);
        rst <= 1'b0;
        tick(1);
        #1;
        chk(cnt[0] | cnt[1], 32'h0);
        chk({16'h0, sts[0] | sts[1]}, 32'h0);
        rd(8'h01, 16);
        // capture mid-tick so the ticker value is unambiguous
        // late enough that the stamp differs from its reset value
        while (cyc % 20 != 8 || cyc < 32'h3C) tick(1);
        stamp = (cyc + 32'h2) / 32'h14;
        @(posedge clk_sys);
        diag_event <= 1'b1;
        @(posedge clk_sys);
        diag_event <= 1'b0;
        for (int i = 0; i < 21; i++) rd(8'h01, i);
        for (int i = 0; i < 5; i++) rd(8'h00, i);
        rd(8'h02, 0);
        for (int m = 0; m < 5; m++) begin
            req(0, 16'h0400);
            @(posedge clk_sys);
            cfg[0] <= 8'(m);
            pd[0] <= (m == 4);
            tick(2);
            req(0, 16'h0004);
            chk(cnt[0], 32'h0);
            chk({30'h0, sts[0][5], sts[0][2]}, 32'h3);
            mv(0, 1'b1, 4);
            chk(cnt[0], 32'(mexp[m]));
            mv(0, 1'b0, 8);
            chk(cnt[0], 32'(-mexp[m]));
        end
        req(0, 16'h0404);
        chk({31'h0, sts[0][2]}, 32'h0);
        mv(0, 1'b1, 4);
        chk(cnt[0], 32'(-2));
        @(posedge clk_sys);
        ctrl[0] <= 16'h0004;
        tick(2);
        @(posedge clk_sys);
        ctrl[0] <= 16'h0404;
        tick(4);
        #1;
        chk({31'h0, sts[0][2]}, 32'h0);
        chk({31'h0, sts[0][13]}, 32'h1);
        req(0, 16'h0040);
        chk({29'h0, sts[0][13:11]}, 32'h0);
        @(posedge clk_sys);
        cfg[1] <= 8'h03;
        req(1, 16'h0004);
        exp1 = 32'h0;
        repeat (40) begin
            rv = rnd();
            mv(1, rv[0], 1);
            exp1 = rv[0] ? exp1 + 32'h1 : exp1 - 32'h1;
        end
        chk(cnt[1], exp1);
        chk(cnt[0], 32'h0);
        tick(5);
        chk(32'(exp_q.size()), 32'h0);
        test_done();
    end
endmodule
`default_nettype wire

// file: tb/dec_enc_model.sv
// encoder model: quadrature or pulse/direction, one per channel
// assumes the bench holds step for one cycle and fwd steady
`timescale 1ns/10ps
`default_nettype none
module dec_enc_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] step,
    input wire logic [1:0] fwd,
    input wire logic [1:0] pd,
    output logic [1:0] track_a,
    output logic [1:0] track_b
);
    logic [1:0][1:0] ph_r;
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 2; i++) begin
            if (rst) begin
                ph_r[i] <= 2'h0;
            end else if (step[i]) begin
                ph_r[i] <= fwd[i] ? ph_r[i] + 2'h1 : ph_r[i] - 2'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            track_a[i] = pd[i] ? ph_r[i][0] : ph_r[i][1] ^ ph_r[i][0];
            track_b[i] = pd[i] ? !fwd[i] : ph_r[i][1];
        end
    end
endmodule
`default_nettype wire
